// [verilog/bscp_defs.vh]
`ifndef BSCP_DEFS_VH
`define BSCP_DEFS_VH
// clock and network link rate
`define BSCP_CLK_HZ          20000000
`define BSCP_NET_BPS         9600
`define BSCP_NET_FRAME_BITS  10
// local baud selector codes
`define BSCP_BAUD_300        3'h0
`define BSCP_BAUD_1200       3'h1
`define BSCP_BAUD_2400       3'h2
`define BSCP_BAUD_4800       3'h3
`define BSCP_BAUD_9600       3'h4
// local baud rates in bits per second
`define BSCP_RATE_300        300
`define BSCP_RATE_1200       1200
`define BSCP_RATE_2400       2400
`define BSCP_RATE_4800       4800
`define BSCP_RATE_9600       9600
// parity selector codes
`define BSCP_PAR_NONE        2'h0
`define BSCP_PAR_EVEN        2'h1
`define BSCP_PAR_ODD         2'h2
// character length code: bits = code + 5
`define BSCP_CHAR_5          2'h0
`define BSCP_CHAR_8          2'h3
// settings after reset
`define BSCP_DEF_PORT_EN     1'h1
`define BSCP_DEF_ECHO        1'h0
`define BSCP_DEF_TRANSP      1'h1
`define BSCP_DEF_BAUD        `BSCP_BAUD_9600
`define BSCP_DEF_CHAR        `BSCP_CHAR_8
`define BSCP_DEF_PARITY      `BSCP_PAR_NONE
`define BSCP_DEF_STOP2       1'h0
`define BSCP_DEF_HOT         1'h0
// sender release idle time in milliseconds
`define BSCP_IDLE_MS         2
// pacing stretch while voice is on the orderwire
`define BSCP_VOICE_SLOW      2
// queue geometry
`define BSCP_FIFO_WIDTH      8
`define BSCP_FIFO_DEPTH      16
`endif

// [verilog/bscp_port.v]
`timescale 1ns/100ps
`include "bscp_defs.vh"

module bscp_fifo #(
  parameter WIDTH = `BSCP_FIFO_WIDTH,
  parameter DEPTH = `BSCP_FIFO_DEPTH,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             flush,
  // filling side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  // draining side
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointers wrap at DEPTH so non power of two depths also work
  always @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // storage, no reset needed on the data path
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // bscp_fifo

module bscp_port #(
  parameter CLK_HZ   = `BSCP_CLK_HZ,
  parameter IDLE_CYC = `BSCP_CLK_HZ / 1000 * `BSCP_IDLE_MS,
  parameter NET_GAP  = `BSCP_CLK_HZ / `BSCP_NET_BPS * `BSCP_NET_FRAME_BITS
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // settings, taken on cfg_load
  input  wire       cfg_load,
  input  wire       cfg_port_en,
  input  wire       cfg_echo_en,
  input  wire       cfg_transparent,
  input  wire [2:0] cfg_baud_sel,
  input  wire [1:0] cfg_char_len,
  input  wire [1:0] cfg_parity,
  input  wire       cfg_stop2,
  input  wire       cfg_dual_unit_hot_standby,
  input  wire       svch_reinit,
  // orderwire voice activity
  input  wire       ow_voice_active,
  // local serial port
  input  wire       ser_rx,
  output reg        ser_tx_a_q,
  output reg        ser_tx_b_q,
  // network side
  input  wire       net_busy,
  input  wire       net_rx_valid,
  input  wire [7:0] net_rx_data,
  input  wire       net_tx_ready,
  output reg        net_tx_valid_q,
  output reg  [7:0] net_tx_data_q,
  output reg        net_sender_q,
  output reg        relay_valid_q,
  output reg  [7:0] relay_data_q,
  // status
  output reg        locked_q
);
  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS  = 2'h2;
  localparam TX_IDLE  = 1'h0;
  localparam TX_SHIFT = 1'h1;

  // baud divider per selector
  function [16:0] baud_div;
    input [2:0] sel;
    integer r;
    begin
      case (sel)
        `BSCP_BAUD_300:  r = CLK_HZ / `BSCP_RATE_300;
        `BSCP_BAUD_1200: r = CLK_HZ / `BSCP_RATE_1200;
        `BSCP_BAUD_2400: r = CLK_HZ / `BSCP_RATE_2400;
        `BSCP_BAUD_4800: r = CLK_HZ / `BSCP_RATE_4800;
        default:         r = CLK_HZ / `BSCP_RATE_9600;
      endcase
      baud_div = r[16:0];
    end
  endfunction

  function [7:0] len_mask;
    input [1:0] c;
    begin
      case (c)
        2'h0:    len_mask = 8'h1f;
        2'h1:    len_mask = 8'h3f;
        2'h2:    len_mask = 8'h7f;
        default: len_mask = 8'hff;
      endcase
    end
  endfunction

  function par_bit;
    input [7:0] d;
    input [1:0] p;
    begin
      par_bit = (p == `BSCP_PAR_ODD) ? ~^d : ^d;
    end
  endfunction

  // settings registers
  reg        port_en_q, echo_q, transp_q, stop2_q, hot_q;
  reg [2:0]  baud_q;
  reg [1:0]  char_q, par_q;
  wire [3:0] nd     = {2'h0, char_q} + 4'h5;
  wire       has_par = (par_q != `BSCP_PAR_NONE);
  wire [16:0] div    = baud_div(baud_q);

  // settings hold their defaults until software loads new ones
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      port_en_q <= `BSCP_DEF_PORT_EN;
      echo_q    <= `BSCP_DEF_ECHO;
      transp_q  <= `BSCP_DEF_TRANSP;
      baud_q    <= `BSCP_DEF_BAUD;
      char_q    <= `BSCP_DEF_CHAR;
      par_q     <= `BSCP_DEF_PARITY;
      stop2_q   <= `BSCP_DEF_STOP2;
      hot_q     <= `BSCP_DEF_HOT;
    end else if (cfg_load) begin
      port_en_q <= cfg_port_en;
      echo_q    <= cfg_echo_en;
      transp_q  <= cfg_transparent;
      baud_q    <= (cfg_baud_sel > `BSCP_BAUD_9600) ? `BSCP_BAUD_9600 : cfg_baud_sel;
      char_q    <= cfg_char_len;
      par_q     <= (cfg_parity == 2'h3) ? `BSCP_PAR_NONE : cfg_parity;
      stop2_q   <= cfg_stop2;
      hot_q     <= cfg_dual_unit_hot_standby;
    end
  end

  // pin synchroniser; a level counts once stages two and three agree
  reg rx_s1_q, rx_s2_q, rx_s3_q, rx_f_q;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      {rx_s1_q, rx_s2_q, rx_s3_q, rx_f_q} <= 4'hf;
    end else begin
      rx_s1_q <= ser_rx;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_f_q <= rx_s3_q;
      end
    end
  end

  // receiver: mid-bit sampling of data, parity and first stop
  reg [1:0]  rx_st_q;
  reg [16:0] rx_cnt_q;
  reg [3:0]  rx_idx_q;
  reg [11:0] rx_sh_q;
  reg        rx_done_q;
  wire [3:0] rx_last = nd + {3'h0, has_par};
  wire [7:0] rx_data = rx_sh_q[7:0] & len_mask(char_q);
  wire       rx_ok   = rx_sh_q[rx_last] &&
                       (!has_par || rx_sh_q[nd] == par_bit(rx_data, par_q));
  always @(posedge clk_sys) begin
    if (sys_rst || svch_reinit) begin
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= 17'h0_0000;
      rx_idx_q  <= 4'h0;
      rx_sh_q   <= 12'h000;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          if (!rx_f_q) begin
            rx_st_q  <= RX_START;
            rx_cnt_q <= {1'b0, div[16:1]};
          end
        end
        RX_START: begin
          if (rx_cnt_q != 17'h0_0000) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else if (rx_f_q) begin
            rx_st_q <= RX_IDLE;  // glitch, not a start bit
          end else begin
            rx_st_q  <= RX_BITS;
            rx_cnt_q <= div - 1'b1;  // a bit is exactly div cycles, no drift
            rx_idx_q <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rx_cnt_q != 17'h0_0000) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else begin
            rx_sh_q[rx_idx_q] <= rx_f_q;
            rx_cnt_q          <= div - 1'b1;  // reload one short, zero is the sample cycle
            rx_idx_q          <= rx_idx_q + 1'b1;
            if (rx_idx_q == rx_last) begin
              rx_st_q   <= RX_IDLE;
              rx_done_q <= 1'b1;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // accepted local character; transparency off strips the top bit
  wire       loc_valid = rx_done_q && rx_ok && port_en_q && !locked_q;
  wire [7:0] loc_char  = transp_q ? rx_data : {1'b0, rx_data[6:0]};

  // outbound queue toward the network
  wire       q_ready, q_valid, q_pop;
  wire [7:0] q_data;
  bscp_fifo #(.WIDTH(8), .DEPTH(`BSCP_FIFO_DEPTH), .AW(4)) u_queue (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .flush     (svch_reinit),
    .in_valid  (loc_valid),
    .in_data   (loc_char),
    .in_ready  (q_ready),
    .out_valid (q_valid),
    .out_data  (q_data),
    .out_ready (q_pop)
  );

  // pending characters for the local transmitter
  reg       echo_pend_q, net_pend_q;
  reg [7:0] echo_char_q, net_char_q;
  reg       tx_st_q;
  reg [11:0] tx_sh_q;
  reg [3:0]  tx_left_q;
  reg [16:0] tx_cnt_q;
  wire       tx_take_echo = (tx_st_q == TX_IDLE) && echo_pend_q;
  wire       tx_take_net  = (tx_st_q == TX_IDLE) && !echo_pend_q && net_pend_q;
  wire [7:0] tx_char      = (echo_pend_q ? echo_char_q : net_char_q) & len_mask(char_q);

  // frame: start, data lsb first, optional parity, stop bits
  reg [11:0] tx_frame;
  integer    i;
  always @* begin
    tx_frame    = 12'hfff;
    tx_frame[0] = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (i < nd) begin
        tx_frame[i+1] = tx_char[i];
      end
    end
    if (has_par) begin
      tx_frame[nd+1'b1] = par_bit(tx_char, par_q);
    end
  end

  // a char arriving while its slot is still full overwrites the pending one; echo slot or queue overflow locks the port
  always @(posedge clk_sys) begin
    if (sys_rst || svch_reinit) begin
      echo_pend_q <= 1'b0;
      net_pend_q  <= 1'b0;
      echo_char_q <= 8'h00;
      net_char_q  <= 8'h00;
      locked_q    <= 1'b0;
    end else begin
      if (loc_valid && echo_q) begin
        echo_pend_q <= 1'b1;
        echo_char_q <= loc_char;
      end else if (tx_take_echo) begin
        echo_pend_q <= 1'b0;
      end
      if (net_rx_valid && port_en_q) begin
        net_pend_q <= 1'b1;
        net_char_q <= net_rx_data;
      end else if (tx_take_net) begin
        net_pend_q <= 1'b0;
      end
      if (loc_valid && (!q_ready || (echo_q && echo_pend_q && !tx_take_echo))) begin
        locked_q <= 1'b1;  // queue full or echo slot overflow
      end
    end
  end

  // local transmitter; only echo or network chars reach it
  always @(posedge clk_sys) begin
    if (sys_rst || svch_reinit) begin
      tx_st_q    <= TX_IDLE;
      tx_sh_q    <= 12'hfff;
      tx_left_q  <= 4'h0;
      tx_cnt_q   <= 17'h0_0000;
      ser_tx_a_q <= 1'b1;
      ser_tx_b_q <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_take_echo || tx_take_net) begin
            tx_st_q   <= TX_SHIFT;
            tx_sh_q   <= tx_frame;
            tx_left_q <= nd + {3'h0, has_par} + {3'h0, stop2_q} + 4'h2;
            tx_cnt_q  <= 17'h0_0000;
          end
        end
        TX_SHIFT: begin
          if (tx_cnt_q != 17'h0_0000) begin
            tx_cnt_q <= tx_cnt_q - 1'b1;
          end else if (tx_left_q == 4'h0) begin
            tx_st_q <= TX_IDLE;
          end else begin
            ser_tx_a_q <= tx_sh_q[0];
            ser_tx_b_q <= hot_q ? tx_sh_q[0] : 1'b1;
            tx_sh_q    <= {1'b1, tx_sh_q[11:1]};
            tx_left_q  <= tx_left_q - 1'b1;
            tx_cnt_q   <= div - 1'b1;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // relay every network character onward regardless of the port setting
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      relay_valid_q <= 1'b0;
      relay_data_q  <= 8'h00;
    end else begin
      relay_valid_q <= net_rx_valid;
      if (net_rx_valid) begin
        relay_data_q <= net_rx_data;
      end
    end
  end

  // sender role and paced network output
  reg [19:0] idle_q;
  reg [16:0] pace_q;
  // stretched gap while voice is on; only the low 17 bits are ever needed
  wire [31:0] gap_slow = NET_GAP * `BSCP_VOICE_SLOW;
  assign q_pop = net_sender_q && q_valid && !net_tx_valid_q && (pace_q == 17'h0_0000);
  always @(posedge clk_sys) begin
    if (sys_rst || svch_reinit) begin
      net_sender_q   <= 1'b0;
      net_tx_valid_q <= 1'b0;
      net_tx_data_q  <= 8'h00;
      idle_q         <= 20'h0_0000;
      pace_q         <= 17'h0_0000;
    end else begin
      if (!net_sender_q && q_valid && !net_busy) begin
        net_sender_q <= 1'b1;
      end else if (net_sender_q && !q_valid && !net_tx_valid_q &&
                   idle_q >= IDLE_CYC[19:0]) begin
        net_sender_q <= 1'b0;
      end
      if (loc_valid || q_valid || !net_sender_q) begin
        idle_q <= 20'h0_0000;
      end else if (idle_q < IDLE_CYC[19:0]) begin
        idle_q <= idle_q + 1'b1;
      end
      if (q_pop) begin
        net_tx_valid_q <= 1'b1;
        net_tx_data_q  <= q_data;
        pace_q <= ow_voice_active ? gap_slow[16:0] : NET_GAP[16:0];
      end else begin
        if (net_tx_valid_q && net_tx_ready) begin
          net_tx_valid_q <= 1'b0;
        end
        if (pace_q != 17'h0_0000) begin
          pace_q <= pace_q - 1'b1;
        end
      end
    end
  end
endmodule // bscp_port

// [bench/bscp_port_chk.sv]
`timescale 1ns/100ps
module bscp_chk (
  // clock and reset
  input wire       clk_sys,
  input wire       sys_rst,
  // inputs of the port
  input wire       svch_reinit,
  input wire       net_busy,
  input wire       net_rx_valid,
  input wire [7:0] net_rx_data,
  input wire       net_tx_ready,
  // outputs of the port
  input wire       ser_tx_a_q,
  input wire       ser_tx_b_q,
  input wire       net_tx_valid_q,
  input wire [7:0] net_tx_data_q,
  input wire       net_sender_q,
  input wire       relay_valid_q,
  input wire [7:0] relay_data_q,
  input wire       locked_q
);
  // single domain; reset masks all but the reset check
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  relay_copy_a: assert property ( // relay always
    net_rx_valid |=> relay_valid_q && relay_data_q == $past(net_rx_data))
    else $error("relay did not follow network input");
  tx_hold_a: assert property ( // no drop
    net_tx_valid_q && !net_tx_ready |=> net_tx_valid_q && $stable(net_tx_data_q))
    else $error("network offer changed before accept");
  send_role_a: assert property (net_tx_valid_q |-> net_sender_q)
    else $error("network offer without sender role");
  take_role_a: assert property ($rose(net_sender_q) |-> !$past(net_busy))
    else $error("sender role taken while network busy");
  mirror_b_a: assert property (!ser_tx_b_q |-> !ser_tx_a_q) // copy only
    else $error("second serial output differs");
  rst_idle_a: assert property ( // reset state
    @(posedge clk_sys) disable iff (1'b0) sys_rst |=> ser_tx_a_q && ser_tx_b_q
      && !net_tx_valid_q && !net_sender_q && !locked_q && !relay_valid_q)
    else $error("outputs not idle after reset");
  reinit_clr_a: assert property (svch_reinit |=> !locked_q && !net_sender_q)
    else $error("reinit left lock or role");
  lock_keep_a: assert property (locked_q && !svch_reinit |=> locked_q)
    else $error("lock cleared without reinit");
  role_drop_a: assert property ( // idle release
    $fell(net_sender_q) && !$past(svch_reinit) |-> !$past(net_tx_valid_q))
    else $error("sender role dropped with offer pending");
endmodule // bscp_chk

bind bscp_port bscp_chk bscp_chk_inst (.*);

// [bench/bscp_term.sv]
`timescale 1ns/100ps
module bscp_term (
  // clock
  input wire clk_sys,
  // serial lines
  input wire rxd,
  output reg txd
);
  integer div;
  // line idles high, as a real terminal holds it
  initial begin
    txd = 1'b1;
    div = 20;
  end
  // one frame lsb first, framing must match the port
  task send(input [7:0] d, input integer n, input [1:0] p, input s2);
    integer i;
    reg [7:0] m;
    begin
      m = d & (8'hff >> (8 - n));
      @(posedge clk_sys) #1 txd = 1'b0;
      for (i = 0; i < n + (p != 0) + 1 + s2; i = i + 1) begin
        repeat (div) @(posedge clk_sys);
        #1 txd = (i < n) ? m[i] : (i == n && p != 0) ? ((p == 2) ^ (^m)) : 1'b1;
      end
      repeat (div) @(posedge clk_sys);
    end
  endtask
  // mid-bit sampling; ok low when no frame shows within 16 bit times
  task recv(output [7:0] d, output ok, input integer n, input [1:0] p);
    integer i;
    integer t;
    begin
      d = 8'h00;
      ok = 1'b0;
      t = 0;
      while (rxd !== 1'b0 && t < 16 * div) begin
        @(posedge clk_sys);
        t = t + 1;
      end
      if (rxd === 1'b0) begin
        repeat (div / 2) @(posedge clk_sys);
        for (i = 0; i < n; i = i + 1) begin
          repeat (div) @(posedge clk_sys);
          d[i] = rxd;
        end
        ok = 1'b1;
        if (p != 0) begin
          repeat (div) @(posedge clk_sys);
          ok = (rxd === ((p == 2) ^ (^d)));
        end
        repeat (div) @(posedge clk_sys);
        ok = ok && (rxd === 1'b1);
      end
    end
  endtask
endmodule // bscp_term

// [bench/bscp_port_tb.sv]
`timescale 1ns/100ps
module bscp_port_tb;
  localparam GAP = 20;
  // inputs of the port
  reg        clk_sys, sys_rst, cfg_load, cfg_port_en, cfg_echo_en, cfg_transparent;
  reg  [2:0] cfg_baud_sel;
  reg  [1:0] cfg_char_len, cfg_parity;
  reg        cfg_stop2, cfg_dual_unit_hot_standby, svch_reinit, ow_voice_active;
  reg        net_busy, net_rx_valid, net_tx_ready;
  reg  [7:0] net_rx_data;
  // outputs of the port, and ser_rx from the terminal
  wire       ser_rx, ser_tx_a_q, ser_tx_b_q, net_tx_valid_q, net_sender_q;
  wire       relay_valid_q, locked_q;
  wire [7:0] net_tx_data_q, relay_data_q;
  // bench state
  integer    err_total, cmp_count, cyc, tl, n, wcnt;
  integer    bdiff, blow;
  integer    dv [0:4] = '{640, 160, 80, 40, 20};
  reg  [1:0] par;
  reg        st;
  reg  [7:0] nq [$];
  integer    tq [$];

  // divisors are 192000 / baud, so 9600 gives 20 cycles a bit
  bscp_port #(.CLK_HZ(192000), .IDLE_CYC(50), .NET_GAP(GAP)) bscp_port_inst (.*);
  bscp_term bscp_term_inst (.clk_sys(clk_sys), .rxd(ser_tx_a_q), .txd(ser_rx));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // network sink stalls three cycles before each accept
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (net_tx_valid_q && net_tx_ready) begin
      nq.push_back(net_tx_data_q);
      tq.push_back(cyc);
    end
    #1;
    wcnt = (net_tx_valid_q && !net_tx_ready) ? wcnt + 1 : 0;
    net_tx_ready = (wcnt == 3);
  end
  // second serial output watch: cycles it differs from the first, cycles it is low
  always @(posedge clk_sys) begin
    bdiff = (ser_tx_b_q !== ser_tx_a_q) ? bdiff + 1 : bdiff;
    blow  = (ser_tx_b_q === 1'b0) ? blow + 1 : blow;
  end
  // hang guard, well above the expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_total = err_total + 1;
    finish_test;
  end

  task chk8(input [7:0] g, input [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk1(input g, input e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
      end
    end
  endtask
  task cfg(input pe, ec, tr, input [2:0] b, input [1:0] l, p, input s2, hs);
    begin
      @(posedge clk_sys) #1;
      {cfg_port_en, cfg_echo_en, cfg_transparent, cfg_baud_sel} = {pe, ec, tr, b};
      {cfg_char_len, cfg_parity, cfg_stop2, cfg_dual_unit_hot_standby} = {l, p, s2, hs};
      cfg_load = 1'b1;
      @(posedge clk_sys) #1 cfg_load = 1'b0;
      bscp_term_inst.div = dv[b];
      n = l + 5;
      par = p;
      st = s2;
    end
  endtask
  // send one char while listening for its echo
  task xfer(input [7:0] e, output [7:0] d, output ok);
    begin
      fork
        bscp_term_inst.send(e, n, par, st);
        bscp_term_inst.recv(d, ok, n, par);
      join
      repeat (bscp_term_inst.div) @(posedge clk_sys);
    end
  endtask
  task getnet(output [7:0] d);
    integer t;
    begin
      t = 0;
      d = 8'hxx;
      while (nq.size() == 0 && t < 3000) begin
        @(posedge clk_sys);
        t = t + 1;
      end
      if (nq.size() != 0) begin
        d = nq.pop_front();
        tl = tq.pop_front();
      end
    end
  endtask
  task net_in(input [7:0] d);
    begin
      @(posedge clk_sys) #1;
      net_rx_valid = 1'b1;
      net_rx_data = d;
      @(posedge clk_sys) #1 net_rx_valid = 1'b0;
      chk1(relay_valid_q, 1'b1); // relayed
      chk8(relay_data_q, d);
    end
  endtask

  task t_default;
    reg [7:0] d;
    reg ok;
    begin
      xfer(8'ha5, d, ok);
      chk1(ok, 1'b0); // echo off
      getnet(d);
      chk8(d, 8'ha5); // 8N1 transparent
      repeat (200) @(posedge clk_sys);
      #1 chk1(net_sender_q, 1'b0); // role freed
    end
  endtask
  // every baud, length, parity and stop choice with echo on
  task t_formats;
    reg [2:0] i;
    reg [7:0] d, e;
    reg ok;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        cfg(1, 1, 1, i, i[1:0], 2'(i % 3), i[0], 0);
        e = (8'h5a + 8'h11 * i) & (8'hff >> (2'd3 - i[1:0]));
        xfer(e, d, ok);
        chk1(ok, 1'b1); // framing
        chk8(d, e); // echo
        getnet(d);
        chk8(d, e); // network copy
      end
    end
  endtask
  task t_transp;
    reg [7:0] d;
    reg ok;
    begin
      cfg(1, 0, 0, 4, 3, 0, 0, 0);
      xfer(8'hc3, d, ok);
      getnet(d);
      chk8(d, 8'h43); // top bit stripped
    end
  endtask
  task t_busy;
    reg [7:0] d;
    reg ok;
    begin
      cfg(1, 0, 1, 4, 3, 0, 0, 0);
      net_busy = 1'b1;
      xfer(8'h31, d, ok);
      repeat (100) @(posedge clk_sys);
      #1 chk1(net_sender_q, 1'b0); // waits
      @(posedge clk_sys) #1 net_busy = 1'b0;
      getnet(d);
      chk8(d, 8'h31); // queued char sent
    end
  endtask
  // overflow the queue, then re-initialise
  task t_lock;
    integer i;
    begin
      @(posedge clk_sys) #1 net_busy = 1'b1;
      for (i = 0; i < 17; i = i + 1)
        bscp_term_inst.send(i[7:0], n, par, st);
      chk1(locked_q, 1'b1); // locked
      @(posedge clk_sys) #1 svch_reinit = 1'b1;
      @(posedge clk_sys) #1 svch_reinit = 1'b0;
      chk1(locked_q, 1'b0);
      net_busy = 1'b0;
      repeat (300) @(posedge clk_sys);
      chk1(nq.size() == 0, 1'b1); // queue flushed
    end
  endtask
  task t_netin;
    reg [7:0] d;
    reg ok;
    begin
      cfg(1, 0, 1, 4, 3, 0, 0, 1);
      bdiff = 0;
      blow = 0;
      fork
        net_in(8'h4e);
        bscp_term_inst.recv(d, ok, n, par);
      join
      chk8(d, 8'h4e); // shown locally
      chk1(bdiff == 0, 1'b1); // both outputs identical
      chk1(blow > 0, 1'b1); // second output carried the frame
      cfg(0, 0, 1, 4, 3, 0, 0, 1);
      fork
        net_in(8'h55);
        bscp_term_inst.recv(d, ok, n, par);
      join
      chk1(ok, 1'b0); // port off
      xfer(8'h66, d, ok);
      repeat (300) @(posedge clk_sys);
      chk1(nq.size() == 0, 1'b1); // input dropped
    end
  endtask
  task t_voice;
    reg [7:0] d;
    integer t0;
    begin
      cfg(1, 0, 1, 4, 3, 0, 0, 0);
      ow_voice_active = 1'b1;
      net_busy = 1'b1;
      bscp_term_inst.send(8'h71, n, par, st);
      bscp_term_inst.send(8'h72, n, par, st);
      #1 net_busy = 1'b0;
      getnet(d);
      chk8(d, 8'h71);
      t0 = tl;
      getnet(d);
      chk8(d, 8'h72); // nothing lost
      chk1(tl - t0 >= 2 * GAP, 1'b1); // slowed pacing
      #1 ow_voice_active = 1'b0;
    end
  endtask

  task finish_test;
    begin
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // defaults at time zero, reset for 20 cycles
  initial begin
    {err_total, cmp_count, cyc, wcnt, n, par, st} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd8, 3'd0};
    {sys_rst, cfg_load, cfg_port_en, cfg_echo_en, cfg_transparent} = 5'b10101;
    {cfg_baud_sel, cfg_char_len, cfg_parity, cfg_stop2} = {3'd4, 2'd3, 2'd0, 1'b0};
    {cfg_dual_unit_hot_standby, svch_reinit, ow_voice_active} = 3'b000;
    {net_busy, net_rx_valid, net_tx_ready, net_rx_data} = 11'h000;
    repeat (20) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    t_default;
    t_formats;
    t_transp;
    t_busy;
    t_lock;
    t_netin;
    t_voice;
    finish_test;
  end
endmodule // bscp_port_tb
